// *** core/status_event_defines.svh ***
/*
 * Bit positions, valid-bit masks and reset values of the status block.
 * Assumes it is included by bare name by the status module.
 */
// Operation
// - Event bits latch and stay until cleared
// - Query or clear-status clears event register
// - Reset command and device clear keep events
// - Reads return binary-weighted register contents
// - Summary bit is OR of enabled events
// - Masks read/write; reads, clear-status keep them
// - Fault bits 0/1: voltage/current unregulated
// - Fault bit 4 fan, bit 9 overvoltage
// - Fault mask cleared only by writing zero
// - Event bit 0 on operation complete marker
// - Event bit 2 on query error cases
// - Bits 3/4/5: device, execution, command error
// - Event bit 7 after power cycle
// - Error bit set pushes error queue entry
// - Masks zeroed by write; event/byte masks power-on per setting
// - Byte bit 3 is fault summary
// - Byte bit 5 is command-event summary
// - Byte bit 4 follows pending reply data
// - Summary bits never latch
// - Byte bit 6 means service requested
// - Clear-status clears byte; event read bit 5
// - Byte mask selects service-request summaries
// - Request bit drives service-request line
// - Serial poll clears only request bit
`ifndef STATUS_EVENT_DEFINES_SVH
`define STATUS_EVENT_DEFINES_SVH

// Fault register bits
`define FLT_VOLT_BIT   0
`define FLT_CURR_BIT   1
`define FLT_FAN_BIT    4
`define FLT_OVP_BIT    9
`define FLT_VALID      16'h0213

// Command event register bits
`define EV_OPC_BIT     0
`define EV_QRY_BIT     2
`define EV_DEV_BIT     3
`define EV_EXE_BIT     4
`define EV_CMD_BIT     5
`define EV_PWR_BIT     7
`define EV_VALID       8'hbd
`define EV_RESET       8'h80

// Summary byte bits
`define SB_FLT_BIT     3
`define SB_MSG_BIT     4
`define SB_EV_BIT      5
`define SB_REQ_BIT     6
`define SB_MASK_VALID  8'hb8

`endif

// *** core/status_event_pkg.sv ***
/*
 * Types of the status block: command codes and the state record.
 * Assumes status_event_defines.svh is on the include path.
 */
package status_event_pkg;

    // Commands from the remote command interpreter
    typedef enum logic [3:0] {
        CMD_NONE      = 4'h0,
        CMD_FLT_READ  = 4'h1,
        CMD_FLT_MWR   = 4'h2,
        CMD_FLT_MRD   = 4'h3,
        CMD_EV_READ   = 4'h4,
        CMD_EV_MWR    = 4'h5,
        CMD_EV_MRD    = 4'h6,
        CMD_SB_READ   = 4'h7,
        CMD_SB_MWR    = 4'h8,
        CMD_SB_MRD    = 4'h9,
        CMD_CLEAR     = 4'ha,
        CMD_POLL      = 4'hb
    } status_cmd_t;

    // Whole state of the block
    typedef struct packed {
        logic [15:0] fltEv;
        logic [15:0] fltMask;
        logic [7:0]  cmdEv;
        logic [7:0]  evMask;
        logic [7:0]  sbMask;
        logic        reqBit;
        logic        reqPrev;
        logic [15:0] rdData;
        logic        rdValid;
        logic        errPush;
    } status_state_t;

endpackage

// *** core/status_event_summary.sv ***
/*
 * Status event summary: fault and command event registers with masks,
 * summary byte and service request line.
 * Assumes commands arrive as one-cycle strobes from the command
 * interpreter, and event inputs are synchronous to clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "status_event_defines.svh"

module status_event_summary
    import status_event_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Stored power-on clear setting
    input  wire logic        pwrOnClear,
    // Regulation and fault conditions (levels)
    input  wire logic        voltUnreg,
    input  wire logic        currUnreg,
    input  wire logic        fanFault,
    input  wire logic        ovpTrip,
    // Command events (one-cycle pulses)
    input  wire logic        opcDone,
    input  wire logic        queryErr,
    input  wire logic        devErr,
    input  wire logic        execErr,
    input  wire logic        syntaxErr,
    // Output buffer holds unread reply data
    input  wire logic        replyPending,
    // Command strobe
    input  wire logic        cmdValid,
    input  wire status_cmd_t cmdCode,
    input  wire logic [15:0] cmdData,
    // Answers
    output logic [15:0]      rdData,
    output logic             rdValid,
    output logic             errQueuePush,
    output logic [7:0]       statusByte,
    output logic             srqOut
);

    status_state_t st_ff;      // Registered state
    status_state_t nxt_st;     // Next state

    logic [15:0] fltSet;       // Fault bits raised this cycle
    logic [7:0]  evSet;        // Command event bits raised this cycle
    logic        fltSum;       // Enabled fault summary
    logic        evSum;        // Enabled command event summary
    logic        reqCond;      // Some enabled summary is set
    logic        isClear;      // Clear-status command
    logic        isFltRd;      // Fault event query
    logic        isEvRd;       // Command event query

    // Raw set vectors; unused positions are masked off
    always_comb begin
        fltSet = 16'h0000;
        fltSet[`FLT_VOLT_BIT] = voltUnreg;
        fltSet[`FLT_CURR_BIT] = currUnreg;
        fltSet[`FLT_FAN_BIT]  = fanFault;
        fltSet[`FLT_OVP_BIT]  = ovpTrip;
        evSet = 8'h00;
        evSet[`EV_OPC_BIT] = opcDone;
        evSet[`EV_QRY_BIT] = queryErr;
        evSet[`EV_DEV_BIT] = devErr;
        evSet[`EV_EXE_BIT] = execErr;
        evSet[`EV_CMD_BIT] = syntaxErr;
    end

    // Summaries are pure combinations of the stored registers, so a
    // cleared event register drops its summary bit at once
    assign fltSum  = |(st_ff.fltEv & st_ff.fltMask);
    assign evSum   = |(st_ff.cmdEv & st_ff.evMask);
    // Enable bit 3 selects the fault summary and bit 5 the event summary
    assign reqCond = |({evSum, replyPending, fltSum}
                       & st_ff.sbMask[`SB_EV_BIT:`SB_FLT_BIT]);

    // Command decode
    assign isClear = cmdValid && (cmdCode == CMD_CLEAR);
    assign isFltRd = cmdValid && (cmdCode == CMD_FLT_READ);
    assign isEvRd  = cmdValid && (cmdCode == CMD_EV_READ);

    // Status byte as seen by polls and queries
    always_comb begin
        statusByte = 8'h00;
        statusByte[`SB_FLT_BIT] = fltSum;
        statusByte[`SB_MSG_BIT] = replyPending;
        statusByte[`SB_EV_BIT]  = evSum;
        statusByte[`SB_REQ_BIT] = st_ff.reqBit;
    end

    // Next-state logic
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdValid = 1'b0;
        nxt_st.reqPrev = reqCond;
        // Error bits always leave a queue entry behind
        nxt_st.errPush = queryErr | devErr | execErr | syntaxErr;

        // Fault events: clear first, then set, so a new event wins
        if (isClear || isFltRd) begin
            nxt_st.fltEv = 16'h0000;
        end
        nxt_st.fltEv = (nxt_st.fltEv | fltSet) & `FLT_VALID;

        // Command events, same set-over-clear ordering
        if (isClear || isEvRd) begin
            nxt_st.cmdEv = 8'h00;
        end
        nxt_st.cmdEv = (nxt_st.cmdEv | evSet) & `EV_VALID;

        // Request bit: raised on a new enabled summary, dropped by a
        // poll, by clear-status or once its cause has gone
        if (isClear || !reqCond) begin
            nxt_st.reqBit = 1'b0;
        end else if (cmdValid && cmdCode == CMD_POLL) begin
            nxt_st.reqBit = 1'b0;
        end
        if (reqCond && !st_ff.reqPrev) begin
            nxt_st.reqBit = 1'b1;
        end

        // Command execution; reset command and device clear never
        // reach this block, so events survive them
        if (cmdValid) begin
            nxt_st.rdValid = 1'b1;
            case (cmdCode)
                CMD_FLT_READ: begin
                    nxt_st.rdData = st_ff.fltEv;
                end
                CMD_FLT_MWR: begin
                    // Only a written zero empties the mask
                    nxt_st.fltMask = cmdData;
                    nxt_st.rdValid = 1'b0;
                end
                CMD_FLT_MRD: begin
                    nxt_st.rdData = st_ff.fltMask;
                end
                CMD_EV_READ: begin
                    nxt_st.rdData = {8'h00, st_ff.cmdEv};
                end
                CMD_EV_MWR: begin
                    nxt_st.evMask = cmdData[7:0];
                    nxt_st.rdValid = 1'b0;
                end
                CMD_EV_MRD: begin
                    nxt_st.rdData = {8'h00, st_ff.evMask};
                end
                CMD_SB_READ, CMD_POLL: begin
                    // Poll and query see the same byte
                    nxt_st.rdData = {8'h00, statusByte};
                end
                CMD_SB_MWR: begin
                    // Request bit itself cannot be enabled
                    nxt_st.sbMask = cmdData[7:0] & `SB_MASK_VALID;
                    nxt_st.rdValid = 1'b0;
                end
                CMD_SB_MRD: begin
                    nxt_st.rdData = {8'h00, st_ff.sbMask};
                end
                CMD_CLEAR: begin
                    // Masks are left alone on purpose
                    nxt_st.rdValid = 1'b0;
                end
                default: begin
                    nxt_st.rdValid = 1'b0;
                end
            endcase
        end
    end

    // State register; power-on reset keeps fault mask, clears event and byte masks if setting asks
    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff.fltEv   <= 16'h0000;
            st_ff.cmdEv   <= `EV_RESET;
            st_ff.reqBit  <= 1'b0;
            st_ff.reqPrev <= 1'b0;
            st_ff.rdData  <= 16'h0000;
            st_ff.rdValid <= 1'b0;
            st_ff.errPush <= 1'b0;
            st_ff.fltMask <= st_ff.fltMask;
            if (pwrOnClear) begin
                st_ff.evMask <= 8'h00;
                st_ff.sbMask <= 8'h00;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign rdData       = st_ff.rdData;
    assign rdValid      = st_ff.rdValid;
    assign errQueuePush = st_ff.errPush;
    assign srqOut       = st_ff.reqBit;

endmodule // status_event_summary

`default_nettype wire

// *** verif/status_event_checker.sv ***
/*
 * Port assertions for the status event summary block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module status_event_checker
    import status_event_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Inputs of the block
    input wire logic        pwrOnClear,
    input wire logic        voltUnreg,
    input wire logic        currUnreg,
    input wire logic        fanFault,
    input wire logic        ovpTrip,
    input wire logic        opcDone,
    input wire logic        queryErr,
    input wire logic        devErr,
    input wire logic        execErr,
    input wire logic        syntaxErr,
    input wire logic        replyPending,
    input wire logic        cmdValid,
    input wire status_cmd_t cmdCode,
    input wire logic [15:0] cmdData,
    // Outputs of the block
    input wire logic [15:0] rdData,
    input wire logic        rdValid,
    input wire logic        errQueuePush,
    input wire logic [7:0]  statusByte,
    input wire logic        srqOut
);
    logic isRead;  // Command that owes an answer
    logic quiet;   // No event input active, so a clear cannot be undone
    assign isRead = cmdValid && (cmdCode inside {CMD_FLT_READ, CMD_FLT_MRD,
        CMD_EV_READ, CMD_EV_MRD, CMD_SB_READ, CMD_SB_MRD, CMD_POLL});
    assign quiet = !(voltUnreg | currUnreg | fanFault | ovpTrip | opcDone
        | queryErr | devErr | execErr | syntaxErr);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    srq_follows_a: assert property (srqOut == statusByte[6])
        else $error("service line differs from request bit");
    unused_zero_a: assert property (statusByte[2:0] == 3'h0 && !statusByte[7])
        else $error("unused status byte bit set");
    mav_live_a: assert property (statusByte[4] == replyPending)
        else $error("message bit does not follow reply data");
    read_answer_a: assert property (isRead |=> rdValid)
        else $error("read without answer");
    no_answer_a: assert property (cmdValid && cmdCode == CMD_CLEAR |=> !rdValid)
        else $error("answer after clear");
    err_push_a: assert property ((queryErr | devErr | execErr | syntaxErr)
        |=> errQueuePush)
        else $error("error event without queue push");
    clear_byte_a: assert property (cmdValid && cmdCode == CMD_CLEAR && quiet
        |=> statusByte[6:5] == 2'h0 && !statusByte[3])
        else $error("summary kept after clear");
    poll_clears_a: assert property (cmdValid && cmdCode == CMD_POLL && statusByte[6]
        |=> rdData[6] && !statusByte[6])
        else $error("poll did not report and drop request");
    ev_query_a: assert property (cmdValid && cmdCode == CMD_EV_READ && quiet
        |=> !statusByte[5])
        else $error("event summary kept after query");
endmodule // status_event_checker
bind status_event_summary status_event_checker u_status_event_checker (
    .clock(clock), .rst(rst), .pwrOnClear(pwrOnClear), .voltUnreg(voltUnreg),
    .currUnreg(currUnreg), .fanFault(fanFault), .ovpTrip(ovpTrip),
    .opcDone(opcDone), .queryErr(queryErr), .devErr(devErr), .execErr(execErr),
    .syntaxErr(syntaxErr), .replyPending(replyPending), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData), .rdValid(rdValid),
    .errQueuePush(errQueuePush), .statusByte(statusByte), .srqOut(srqOut));
`default_nettype wire

// *** verif/bus_controller_model.sv ***
/*
 * Remote bus controller: counts service requests it is sent.
 * Assumes the request line is synchronous to clock.
 */
`timescale 1ns/1ns
`default_nettype none
module bus_controller_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       srqOut,
    output var  logic [7:0] srqCount
);
    logic srqPrev;  // Edge detect, a held line is one request
    // Count each new request
    always @(posedge clock) begin
        srqPrev <= rst ? 1'b0 : srqOut;
        if (rst) begin
            srqCount <= 8'h00;
        end else if (srqOut && !srqPrev) begin
            srqCount <= srqCount + 8'h01;
        end
    end
endmodule // bus_controller_model
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Self-checking bench for the status event summary block.
 * Assumes a 20 MHz clock and the command codes of the package.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import status_event_pkg::*;
    logic        clock, rst, replyPending, cmdValid, rdValid, errQueuePush, srqOut;
    logic [8:0]  ev;  // volt,curr,fan,ovp,opc,qry,dev,exe,syntax
    status_cmd_t cmdCode;
    logic [15:0] cmdData, rdData;
    logic [7:0]  statusByte, srqCount;
    int          failures, n_tests;
    status_event_summary u_status_event_summary (.clock(clock), .rst(rst),
        .pwrOnClear(1'b1), .voltUnreg(ev[8]), .currUnreg(ev[7]), .fanFault(ev[6]),
        .ovpTrip(ev[5]), .opcDone(ev[4]), .queryErr(ev[3]), .devErr(ev[2]),
        .execErr(ev[1]), .syntaxErr(ev[0]), .replyPending(replyPending),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData),
        .rdValid(rdValid), .errQueuePush(errQueuePush), .statusByte(statusByte),
        .srqOut(srqOut));
    bus_controller_model u_bus_controller_model (.clock(clock), .rst(rst),
        .srqOut(srqOut), .srqCount(srqCount));
    // Compare one value
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One command strobe; returns just after the answer edge
    task automatic cmd(input status_cmd_t c, input logic [15:0] d);
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdData <= d;
        @(posedge clock);
        cmdValid <= 1'b0;
        #1;
    endtask
    // One-cycle event pulse, then let summaries and request settle
    task automatic pulse(input logic [8:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 9'h000;
        @(posedge clock);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Power-on bit, then events latch and clear on query
    task automatic t_events;
        cmd(CMD_EV_READ, 16'h0);
        chk("power bit", 16'h0080, rdData);
        pulse(9'h1ff);
        cmd(CMD_FLT_READ, 16'h0);
        chk("fault events", 16'h0213, rdData);
        cmd(CMD_EV_READ, 16'h0);
        chk("events", 16'h003d, rdData);
        cmd(CMD_FLT_READ, 16'h0);
        chk("fault cleared", 16'h0000, rdData);
        $display("test events done");
    endtask
    // Summaries, service request, poll and clear
    task automatic t_summary;
        cmd(CMD_EV_MWR, 16'h00ff);
        cmd(CMD_SB_MWR, 16'h0028);
        pulse(9'h002);
        chk("request byte", 16'h0060, {8'h0, statusByte});
        cmd(CMD_POLL, 16'h0);
        chk("requests seen", 16'h0001, {8'h0, srqCount});
        chk("poll answer", 16'h0060, rdData);
        chk("after poll", 16'h0020, {8'h0, statusByte});
        cmd(CMD_EV_READ, 16'h0);
        chk("after query", 16'h0000, {8'h0, statusByte});
        cmd(CMD_SB_MWR, 16'h0008);
        cmd(CMD_FLT_MWR, 16'h0010);
        pulse(9'h040);
        chk("fault summary", 16'h0048, {8'h0, statusByte});
        cmd(CMD_CLEAR, 16'h0);
        chk("after clear", 16'h0000, {8'h0, statusByte});
        cmd(CMD_FLT_MRD, 16'h0);
        chk("fault mask", 16'h0010, rdData);
        cmd(CMD_EV_MRD, 16'h0);
        chk("event mask", 16'h00ff, rdData);
        cmd(CMD_FLT_MWR, 16'h0);
        cmd(CMD_FLT_MRD, 16'h0);
        chk("fault mask zero", 16'h0000, rdData);
        $display("test summary done");
    endtask
    // Reply data shows at once in the message bit
    task automatic t_message;
        @(posedge clock);
        replyPending <= 1'b1;
        @(posedge clock);
        #1;
        chk("message bit", 16'h0010, {8'h0, statusByte});
        @(posedge clock);
        replyPending <= 1'b0;
        $display("test message done");
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Cut a hang short
    initial begin
        repeat (2000) @(posedge clock);
        failures++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        ev = 9'h000;
        replyPending = 1'b0;
        cmdValid = 1'b0;
        cmdCode = CMD_NONE;
        cmdData = 16'h0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        cmd(CMD_FLT_MWR, 16'h0);
        t_events();
        t_summary();
        t_message();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
